//--- logic/cpu_decode_pkg.sv
// Purpose: shared constants and types for the instruction decode stage
// Assumes: 32-bit aligned instruction words, four coprocessor slots
// Notes: encodings of the operation groups live here; the checks and the bench also spell some out as literals
package cpu_decode_pkg;

    // ==========================================================
    // field layout of an instruction word
    localparam int INSTR_W = 32;
    localparam int OPCODE_MSB = 31;
    localparam int OPCODE_LSB = 26;
    localparam int SOURCE_MSB = 25;
    localparam int SOURCE_LSB = 21;
    localparam int TARGET_MSB = 20;
    localparam int TARGET_LSB = 16;
    localparam int DEST_MSB = 15;
    localparam int DEST_LSB = 11;
    localparam int SHAMT_MSB = 10;
    localparam int SHAMT_LSB = 6;
    localparam int FUNC_MSB = 5;
    localparam int FUNC_LSB = 0;
    localparam int IMM_MSB = 15;
    localparam int JIDX_MSB = 25;
    localparam int JUMP_LOW_W = 28;
    localparam int COP_OPERATE_BIT = 25;
    localparam int FP_CC_SEL_MSB = 20;
    localparam int FP_CC_SEL_LSB = 18;
    localparam int FP_TRUE_BIT = 16;
    localparam int COP_REGS = 32;

    // ==========================================================
    // primary operation codes and function codes
    localparam logic [5:0] OPC_REG_FUNCTION = 6'h00;
    localparam logic [5:0] OPC_REG_IMMEDIATE = 6'h01;
    localparam logic [3:0] OPC_COP_GROUP = 4'h4;
    localparam logic [5:0] OPC_FLOAT_EXTENDED = 6'h13;
    localparam logic [5:0] OPC_HINT_OFFSET = 6'h33;
    localparam logic [1:0] OPC_XFER_GROUP = 2'h3;
    localparam logic [5:0] FUNC_COPY_FP = 6'h01;
    localparam logic [5:0] FUNC_COPY_ZERO = 6'h0a;
    localparam logic [5:0] FUNC_COPY_NONZERO = 6'h0b;
    localparam logic [5:0] FUNC_HINT_INDEXED = 6'h0f;
    localparam logic [4:0] COP_MOVE_FROM = 5'h00;
    localparam logic [4:0] COP_MOVE_FROM_WIDE = 5'h01;
    localparam logic [4:0] COP_CTRL_FROM = 5'h02;
    localparam logic [4:0] COP_MOVE_TO = 5'h04;
    localparam logic [4:0] COP_MOVE_TO_WIDE = 5'h05;
    localparam logic [4:0] COP_CTRL_TO = 5'h06;
    localparam logic [31:0] NOP_WORD = 32'h0000_0000;
    localparam logic [31:0] IDLE_SLOT_WORD = 32'h0000_0040;

    // one bit per assigned encoding; a clear bit marks a reserved encoding
    localparam logic [63:0] OPCODE_VALID = 64'he6ee_4f7f_00ff_ffff;
    localparam logic [63:0] FUNC_VALID = 64'h005f_0cff_0f0f_bfdf;
    localparam logic [31:0] REGISTER_IMMEDIATE_GROUP_VALID = 32'h000f_5f0f;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        UNIT_SYSTEM,
        UNIT_FLOAT,
        UNIT_CUSTOM,
        UNIT_FLOAT_EXT
    } cop_unit_t;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_IDLE_SLOT,
        OP_INTEGER,
        OP_COPY_IF_NONZERO,
        OP_COPY_IF_ZERO,
        OP_COPY_IF_FP_FALSE,
        OP_COPY_IF_FP_TRUE,
        OP_HINT_OFFSET,
        OP_HINT_INDEXED,
        OP_COP_MOVE,
        OP_COP_XFER,
        OP_COP_OPERATE,
        OP_RESERVED
    } op_class_t;

endpackage : cpu_decode_pkg

//--- logic/cop_route_if.sv
// Purpose: carries one instruction to the coprocessor router and its verdict back
// Assumes: purely combinational path inside one clock domain
// Notes: decoder side drives the word and the enables
`timescale 1ns/1ps
`default_nettype none
interface cop_route_if;
    logic [31:0] instr;
    logic [3:0] enable;
    logic hit;
    cpu_decode_pkg::cop_unit_t unit;
    logic is_move;
    logic is_xfer;
    logic ctrl_set;
    logic hint_indexed;
    logic unusable;
    logic reserved;

    // ==========================================================
    modport decoder (output instr, output enable, input hit, input unit, input is_move,
        input is_xfer, input ctrl_set, input hint_indexed, input unusable, input reserved);
    modport router (input instr, input enable, output hit, output unit, output is_move,
        output is_xfer, output ctrl_set, output hint_indexed, output unusable,
        output reserved);
endinterface : cop_route_if
`default_nettype wire

//--- logic/cop_route.sv
// Purpose: classifies coprocessor instructions and picks the unit that owns them
// Assumes: enable bits come from system control on the same clock
// Notes: operations other than moves, transfers and the indexed hint are passed on undecoded
`timescale 1ns/1ps
`default_nettype none
module cop_route (
    cop_route_if.router bus
);
    logic [5:0] opcode;
    logic [4:0] sub_op;
    logic cop_op;
    logic xfer_slot;
    logic [1:0] unit_idx;
    logic [1:0] enable_idx;

    // ==========================================================
    // group detection: operate space and data transfer slots
    assign opcode = bus.instr[cpu_decode_pkg::OPCODE_MSB:cpu_decode_pkg::OPCODE_LSB];
    assign sub_op = bus.instr[cpu_decode_pkg::SOURCE_MSB:cpu_decode_pkg::SOURCE_LSB];
    assign unit_idx = opcode[1:0];
    assign cop_op = (opcode[5:2] == cpu_decode_pkg::OPC_COP_GROUP);
    assign xfer_slot = (opcode[5:4] == cpu_decode_pkg::OPC_XFER_GROUP);

    // unit numbers map straight from the low opcode bits
    assign bus.unit = cpu_decode_pkg::cop_unit_t'(unit_idx);
    // only units 1 and 2 own load/store slots
    assign bus.is_xfer = xfer_slot && (unit_idx == 2'd1 || unit_idx == 2'd2);
    assign bus.hit = cop_op || bus.is_xfer;

    // moves are the only operate-space ops decoded here
    always_comb begin
        bus.is_move = 1'b0;
        bus.ctrl_set = 1'b0;
        if (cop_op && opcode != cpu_decode_pkg::OPC_FLOAT_EXTENDED
            && !bus.instr[cpu_decode_pkg::COP_OPERATE_BIT]) begin
            case (sub_op)
                cpu_decode_pkg::COP_MOVE_FROM, cpu_decode_pkg::COP_MOVE_FROM_WIDE,
                cpu_decode_pkg::COP_MOVE_TO, cpu_decode_pkg::COP_MOVE_TO_WIDE: begin
                    bus.is_move = 1'b1;
                end
                cpu_decode_pkg::COP_CTRL_FROM, cpu_decode_pkg::COP_CTRL_TO: begin
                    bus.is_move = 1'b1;
                    bus.ctrl_set = 1'b1; // control set, 5-bit index
                end
                default: begin
                    bus.is_move = 1'b0; // left to the coprocessor itself
                end
            endcase
        end
    end

    // register-plus-register hint lives in the extended float space
    assign bus.hint_indexed = (opcode == cpu_decode_pkg::OPC_FLOAT_EXTENDED)
        && (bus.instr[cpu_decode_pkg::FUNC_MSB:cpu_decode_pkg::FUNC_LSB]
            == cpu_decode_pkg::FUNC_HINT_INDEXED);

    // system control has no load/store slot of its own
    assign bus.reserved = xfer_slot && (unit_idx == 2'd0);

    // extended float space is gated by the primary float enable
    assign enable_idx = (unit_idx == 2'd3) ? 2'd1 : unit_idx;
    assign bus.unusable = bus.hit && !bus.enable[enable_idx];
endmodule : cop_route
`default_nettype wire

//--- logic/cpu_instruction_decode.sv
// Purpose: one-stage decode of integer instruction words into fields and classes
// Assumes: fetch words, condition operands and enables arrive on i_clock
// Notes: outputs appear one cycle after i_instr_valid; there is no stall
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_decode (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire logic [1:0] i_fetch_addr_low,
    input wire logic [31:0] i_cond_value,
    input wire logic [7:0] i_fp_cc,
    input wire logic [3:0] i_cop_enable,
    output logic o_valid,
    output var cpu_decode_pkg::op_class_t o_op_class,
    output logic [5:0] o_opcode,
    output logic [4:0] o_source_reg,
    output logic [4:0] o_target_reg,
    output logic [4:0] o_dest_reg,
    output logic [4:0] o_shift_amount,
    output logic [5:0] o_function,
    output logic [31:0] o_imm_sext,
    output logic [27:0] o_jump_target,
    output logic o_target_is_function,
    output logic o_copy_write_en,
    output var cpu_decode_pkg::cop_unit_t o_cop_unit,
    output logic o_cop_ctrl_set,
    output logic o_issue_alone,
    output logic o_exc_reserved,
    output logic o_exc_cop_unusable,
    output logic o_exc_addr_align
);
    cop_route_if cop ();
    cpu_decode_pkg::op_class_t dec_class;
    logic [5:0] opcode;
    logic [5:0] func;
    logic [4:0] target;
    logic fp_sel_bit;
    logic copy_take;
    logic misaligned;
    logic reserved;

    cpu_decode_pkg::op_class_t class_q;
    logic valid_q;
    logic copy_q;
    logic alone_q;
    logic exc_res_q;
    logic exc_cop_q;
    logic exc_align_q;
    logic tgt_fn_q;
    logic ctrl_q;
    cpu_decode_pkg::cop_unit_t unit_q;
    logic [31:0] word_q;

    // ==========================================================
    // field extraction, fixed positions for every format
    assign opcode = i_instr[cpu_decode_pkg::OPCODE_MSB:cpu_decode_pkg::OPCODE_LSB];
    assign target = i_instr[cpu_decode_pkg::TARGET_MSB:cpu_decode_pkg::TARGET_LSB];
    assign func = i_instr[cpu_decode_pkg::FUNC_MSB:cpu_decode_pkg::FUNC_LSB];
    assign misaligned = (i_fetch_addr_low != 2'b00);

    // coprocessor classification is shared with the router
    assign cop.instr = i_instr;
    assign cop.enable = i_cop_enable;
    cop_route router (
        .bus(cop)
    );

    // ==========================================================
    // class decode; idle slot checked before the generic shift group
    always_comb begin
        dec_class = cpu_decode_pkg::OP_INTEGER;
        if (i_instr == cpu_decode_pkg::NOP_WORD) begin
            dec_class = cpu_decode_pkg::OP_NOP;
        end else if (i_instr == cpu_decode_pkg::IDLE_SLOT_WORD) begin
            dec_class = cpu_decode_pkg::OP_IDLE_SLOT;
        end else if (!cpu_decode_pkg::OPCODE_VALID[opcode] || cop.reserved) begin
            dec_class = cpu_decode_pkg::OP_RESERVED;
        end else if (cop.hint_indexed) begin
            dec_class = cpu_decode_pkg::OP_HINT_INDEXED;
        end else if (opcode == cpu_decode_pkg::OPC_HINT_OFFSET) begin
            dec_class = cpu_decode_pkg::OP_HINT_OFFSET;
        end else if (cop.hit) begin
            if (cop.is_move) begin
                dec_class = cpu_decode_pkg::OP_COP_MOVE;
            end else if (cop.is_xfer) begin
                dec_class = cpu_decode_pkg::OP_COP_XFER;
            end else begin
                dec_class = cpu_decode_pkg::OP_COP_OPERATE;
            end
        end else if (opcode == cpu_decode_pkg::OPC_REG_FUNCTION) begin
            case (func)
                cpu_decode_pkg::FUNC_COPY_NONZERO: begin
                    dec_class = cpu_decode_pkg::OP_COPY_IF_NONZERO;
                end
                cpu_decode_pkg::FUNC_COPY_ZERO: begin
                    dec_class = cpu_decode_pkg::OP_COPY_IF_ZERO;
                end
                cpu_decode_pkg::FUNC_COPY_FP: begin
                    dec_class = i_instr[cpu_decode_pkg::FP_TRUE_BIT]
                        ? cpu_decode_pkg::OP_COPY_IF_FP_TRUE
                        : cpu_decode_pkg::OP_COPY_IF_FP_FALSE;
                end
                default: begin
                    if (!cpu_decode_pkg::FUNC_VALID[func]) begin
                        dec_class = cpu_decode_pkg::OP_RESERVED;
                    end
                end
            endcase
        end else if (opcode == cpu_decode_pkg::OPC_REG_IMMEDIATE
            && !cpu_decode_pkg::REGISTER_IMMEDIATE_GROUP_VALID[target]) begin
            dec_class = cpu_decode_pkg::OP_RESERVED;
        end
    end

    // ==========================================================
    // copy condition: zero test on a full word, or one selected float flag
    assign fp_sel_bit =
        i_fp_cc[i_instr[cpu_decode_pkg::FP_CC_SEL_MSB:cpu_decode_pkg::FP_CC_SEL_LSB]];
    always_comb begin
        case (dec_class)
            cpu_decode_pkg::OP_COPY_IF_NONZERO: begin
                copy_take = (i_cond_value != 32'h0000_0000);
            end
            cpu_decode_pkg::OP_COPY_IF_ZERO: begin
                copy_take = (i_cond_value == 32'h0000_0000);
            end
            cpu_decode_pkg::OP_COPY_IF_FP_FALSE: copy_take = !fp_sel_bit;
            cpu_decode_pkg::OP_COPY_IF_FP_TRUE: copy_take = fp_sel_bit;
            default: copy_take = 1'b0;
        endcase
    end
    assign reserved = (dec_class == cpu_decode_pkg::OP_RESERVED);

    // ==========================================================
    // decoded class and handshake, registered
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            valid_q <= 1'b0;
            class_q <= cpu_decode_pkg::OP_NOP;
        end else begin
            valid_q <= i_instr_valid;
            class_q <= i_instr_valid ? dec_class : cpu_decode_pkg::OP_NOP;
        end
    end

    // raw word kept so every field comes from a flip-flop
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_q <= 32'h0000_0000;
        end else if (i_instr_valid) begin
            word_q <= i_instr;
        end
    end

    // copy enable and issue behaviour; only one bubble per idle slot
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            copy_q <= 1'b0;
            alone_q <= 1'b0;
            tgt_fn_q <= 1'b0;
        end else begin
            copy_q <= i_instr_valid && copy_take && !misaligned;
            alone_q <= i_instr_valid && (dec_class == cpu_decode_pkg::OP_IDLE_SLOT);
            tgt_fn_q <= i_instr_valid && (opcode == cpu_decode_pkg::OPC_REG_IMMEDIATE);
        end
    end

    // coprocessor routing, held with the word it belongs to
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            unit_q <= cpu_decode_pkg::UNIT_SYSTEM;
            ctrl_q <= 1'b0;
        end else if (i_instr_valid) begin
            unit_q <= cop.unit;
            ctrl_q <= cop.hit && cop.ctrl_set;
        end
    end

    // exceptions: alignment wins, then reserved, then unusable unit
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            exc_align_q <= 1'b0;
            exc_res_q <= 1'b0;
            exc_cop_q <= 1'b0;
        end else begin
            exc_align_q <= i_instr_valid && misaligned;
            exc_res_q <= i_instr_valid && !misaligned && reserved;
            exc_cop_q <= i_instr_valid && !misaligned && !reserved && cop.unusable;
        end
    end

    // ==========================================================
    // outputs: fields cut from the stored word
    assign o_valid = valid_q;
    assign o_op_class = class_q;
    assign o_opcode = word_q[cpu_decode_pkg::OPCODE_MSB:cpu_decode_pkg::OPCODE_LSB];
    assign o_source_reg =
        word_q[cpu_decode_pkg::SOURCE_MSB:cpu_decode_pkg::SOURCE_LSB];
    assign o_target_reg =
        word_q[cpu_decode_pkg::TARGET_MSB:cpu_decode_pkg::TARGET_LSB];
    assign o_dest_reg = word_q[cpu_decode_pkg::DEST_MSB:cpu_decode_pkg::DEST_LSB];
    assign o_shift_amount =
        word_q[cpu_decode_pkg::SHAMT_MSB:cpu_decode_pkg::SHAMT_LSB];
    assign o_function = word_q[cpu_decode_pkg::FUNC_MSB:cpu_decode_pkg::FUNC_LSB];
    assign o_imm_sext = {{16{word_q[cpu_decode_pkg::IMM_MSB]}},
        word_q[cpu_decode_pkg::IMM_MSB:0]};
    assign o_jump_target = {word_q[cpu_decode_pkg::JIDX_MSB:0], 2'b00};
    assign o_target_is_function = tgt_fn_q;
    assign o_copy_write_en = copy_q;
    assign o_cop_unit = unit_q;
    assign o_cop_ctrl_set = ctrl_q;
    assign o_issue_alone = alone_q;
    assign o_exc_reserved = exc_res_q;
    assign o_exc_cop_unusable = exc_cop_q;
    assign o_exc_addr_align = exc_align_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    copy_nonzero_a: assert property (
        i_instr_valid && !misaligned && opcode == cpu_decode_pkg::OPC_REG_FUNCTION
            && func == cpu_decode_pkg::FUNC_COPY_NONZERO
        |=> o_op_class == cpu_decode_pkg::OP_COPY_IF_NONZERO
            && o_copy_write_en == ($past(i_cond_value) != 32'h0000_0000))
        else $error("copy_if_nonzero write enable wrong");

    copy_zero_a: assert property (
        i_instr_valid && !misaligned && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h0a
        |=> o_op_class == cpu_decode_pkg::OP_COPY_IF_ZERO
            && o_copy_write_en == ($past(i_cond_value) == 32'h0000_0000))
        else $error("copy_if_zero decode or enable wrong");

    copy_fp_a: assert property (
        i_instr_valid && !misaligned && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h01
        |=> o_copy_write_en == ($past(i_fp_cc[i_instr[20:18]]) == $past(i_instr[16])))
        else $error("float condition copy wrong");

    zero_word_a: assert property (
        i_instr_valid && i_instr == 32'h0000_0000
        |=> o_valid && o_op_class == cpu_decode_pkg::OP_NOP && !o_copy_write_en
            && !o_exc_reserved)
        else $error("all-zero word not a no-operation");

    idle_slot_a: assert property (
        i_instr_valid && i_instr == cpu_decode_pkg::IDLE_SLOT_WORD ##1 !i_instr_valid
        |-> o_issue_alone ##1 !o_issue_alone)
        else $error("idle slot not exactly one issue cycle");

    no_cop0_xfer_a: assert property (
        i_instr_valid && !misaligned && i_instr[31:30] == 2'b11 && i_instr[27:26] == 2'b00
        |=> o_exc_reserved && o_op_class == cpu_decode_pkg::OP_RESERVED)
        else $error("system control load or store not refused");

    fp_unusable_a: assert property (
        i_instr_valid && !misaligned && i_instr[31:26] == 6'h11 && !i_cop_enable[1]
        |=> o_exc_cop_unusable && o_cop_unit == cpu_decode_pkg::UNIT_FLOAT)
        else $error("disabled float unit not trapped");

    jump_index_a: assert property (
        i_instr_valid |=> o_jump_target == {$past(i_instr[25:0]), 2'b00})
        else $error("jump target bits wrong");

    imm_sign_a: assert property (
        i_instr_valid |=> o_imm_sext[31:16] == {16{$past(i_instr[15])}}
            && o_imm_sext[15:0] == $past(i_instr[15:0]))
        else $error("immediate not sign extended");

    hint_indexed_a: assert property (
        i_instr_valid && i_instr[31:26] == 6'h13 && i_instr[5:0] == 6'h0f
        |=> o_op_class == cpu_decode_pkg::OP_HINT_INDEXED)
        else $error("indexed hint not decoded");

    align_first_a: assert property (
        i_instr_valid && misaligned |=> o_exc_addr_align && !o_exc_reserved
            && !o_exc_cop_unusable && !o_copy_write_en)
        else $error("misaligned word not flagged alone");

    cover_copy_taken_c: cover property (
        i_instr_valid && dec_class == cpu_decode_pkg::OP_COPY_IF_NONZERO ##1 o_copy_write_en);
    cover_idle_slot_c: cover property (
        i_instr_valid && i_instr == cpu_decode_pkg::IDLE_SLOT_WORD ##1 o_issue_alone);
    cover_reserved_c: cover property (o_exc_reserved);
    cover_unusable_c: cover property (o_exc_cop_unusable);
endmodule : cpu_instruction_decode
`default_nettype wire

//--- dv/fetch_model.sv
// Purpose: fetch stage stand-in that presents one word per call
// Assumes: driven just after a rising edge, answer sampled one edge later
// Notes: a released bus shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
    input wire logic i_clock,
    output logic o_instr_valid,
    output logic [31:0] o_instr,
    output logic [1:0] o_addr_low,
    output logic [31:0] o_cond_value,
    output logic [7:0] o_fp_cc,
    output logic [3:0] o_cop_enable
);
    // ==========================================================
    // idle bus at time zero
    initial begin
        o_instr_valid = 1'b0;
        o_instr = 32'h0000_0000;
        o_addr_low = 2'h0;
        o_cond_value = 32'h0000_0000;
        o_fp_cc = 8'h00;
        o_cop_enable = 4'h0;
    end

    // one word held for exactly one edge; flipped after so stale data never matches
    task automatic issue(input logic [31:0] w, input logic [31:0] c, input logic [7:0] cc,
            input logic [3:0] en, input logic [1:0] al);
        @(posedge i_clock);
        #1;
        o_instr_valid = 1'b1;
        o_instr = w;
        o_addr_low = al;
        o_cond_value = c;
        o_fp_cc = cc;
        o_cop_enable = en;
        @(posedge i_clock);
        #1;
        o_instr_valid = 1'b0;
        o_instr = ~w;
        o_cond_value = ~c;
    endtask : issue
endmodule : fetch_model
`default_nettype wire

//--- dv/cpu_instruction_decode_tb.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: answer appears one edge after the word is taken
// Notes: expectations come from the field layout and chosen encodings
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_decode_tb;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic vld_in, valid, tfn, cwe, ctl, alone, rsv, unu, aln;
    logic [31:0] instr, cond, imm;
    logic [1:0] alow;
    logic [7:0] fcc;
    logic [3:0] en;
    logic [5:0] opc, fn;
    logic [4:0] src, tgt, dst, sh;
    logic [27:0] jt;
    cpu_decode_pkg::op_class_t cls;
    cpu_decode_pkg::cop_unit_t unit;
    int err_count = 0;
    int n_tests = 0;

    // ==========================================================
    // clock and parts
    always #2 i_clock = ~i_clock;
    fetch_model i_fetch (.i_clock(i_clock), .o_instr_valid(vld_in), .o_instr(instr),
        .o_addr_low(alow), .o_cond_value(cond), .o_fp_cc(fcc), .o_cop_enable(en));
    cpu_instruction_decode i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_instr_valid(vld_in), .i_instr(instr), .i_fetch_addr_low(alow),
        .i_cond_value(cond), .i_fp_cc(fcc), .i_cop_enable(en), .o_valid(valid),
        .o_op_class(cls), .o_opcode(opc), .o_source_reg(src), .o_target_reg(tgt),
        .o_dest_reg(dst), .o_shift_amount(sh), .o_function(fn), .o_imm_sext(imm),
        .o_jump_target(jt), .o_target_is_function(tfn), .o_copy_write_en(cwe),
        .o_cop_unit(unit), .o_cop_ctrl_set(ctl), .o_issue_alone(alone),
        .o_exc_reserved(rsv), .o_exc_cop_unusable(unu), .o_exc_addr_align(aln));

    // ==========================================================
    // comparison and verdict
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic ck_cls(input cpu_decode_pkg::op_class_t e);
        check("class", 32'(cls), 32'(e));
    endtask : ck_cls

    task automatic end_sim();
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // scenarios
    // field split; a misaligned reserved word must raise only the align flag
    task automatic t_fields();
        i_fetch.issue(32'h8d2a_f7c4, 32'h0, 8'h00, 4'hf, 2'b00);
        check("opcode", 32'(opc), 32'h23);
        check("regs", 32'({src, tgt, dst}), 32'h255e);
        check("sa_fn", 32'({sh, fn}), 32'h7c4);
        check("imm", imm, 32'hffff_f7c4);
        check("jump", 32'(jt), 32'h04ab_df10);
        ck_cls(cpu_decode_pkg::OP_INTEGER);
        i_fetch.issue(32'h6000_0000, 32'h0, 8'h00, 4'hf, 2'b01);
        check("align", 32'({aln, rsv}), 32'h2);
    endtask : t_fields

    // zero word, then idle slot that must last one cycle only
    task automatic t_nop();
        i_fetch.issue(32'h0, 32'h0, 8'h00, 4'hf, 2'b00);
        ck_cls(cpu_decode_pkg::OP_NOP);
        check("nop", 32'({valid, rsv}), 32'h2);
        i_fetch.issue(32'h40, 32'h0, 8'h00, 4'hf, 2'b00);
        ck_cls(cpu_decode_pkg::OP_IDLE_SLOT);
        check("idle", 32'(alone), 32'h1);
        @(posedge i_clock);
        #1;
        check("idle_end", 32'(alone), 32'h0);
    endtask : t_nop

    // j[2] float or integer condition, j[1] sense, j[0] condition cleared
    task automatic t_copy();
        logic [31:0] w;
        logic [31:0] e;
        for (int j = 0; j < 8; j++) begin
            w = j[2] ? {15'h4, j[1], 16'h0801} : {28'h0085_180, 3'b101, ~j[1]};
            e = 32'(cpu_decode_pkg::OP_COPY_IF_NONZERO) + 32'(j[2:1]);
            i_fetch.issue(w, j[0] ? 32'h0 : 32'hffff_fff0, j[0] ? 8'h00 : 8'h04, 4'hf, 2'b00);
            check("class", 32'(cls), e);
            check("copy_we", 32'(cwe), 32'(j[2] ? j[0] != j[1] : j[0] == j[1]));
        end
    endtask : t_copy

    // coprocessor routing, hints, register-immediate group and reserved slots
    task automatic t_cop();
        for (int u = 0; u < 3; u++) begin
            i_fetch.issue({4'h4, u[1:0], 5'h02, 21'h0}, 32'h0, 8'h00, 4'hf, 2'b00);
            check("unit", 32'(unit), u);
            check("move_ctl", 32'({ctl, cls == cpu_decode_pkg::OP_COP_MOVE}), 32'h3);
        end
        i_fetch.issue(32'h4400_0000, 32'h0, 8'h00, 4'hd, 2'b00);
        check("unusable", 32'(unu), 32'h1);
        i_fetch.issue(32'h4a00_0000, 32'h0, 8'h00, 4'hf, 2'b00);
        ck_cls(cpu_decode_pkg::OP_COP_OPERATE);
        i_fetch.issue(32'hc400_0000, 32'h0, 8'h00, 4'hf, 2'b00);
        ck_cls(cpu_decode_pkg::OP_COP_XFER);
        i_fetch.issue(32'hc000_0000, 32'h0, 8'h00, 4'hf, 2'b00);
        check("sys_xfer", 32'(rsv), 32'h1);
        i_fetch.issue(32'h6000_0000, 32'h0, 8'h00, 4'hf, 2'b00);
        ck_cls(cpu_decode_pkg::OP_RESERVED);
        i_fetch.issue(32'hcc43_0010, 32'h0, 8'h00, 4'hf, 2'b00);
        ck_cls(cpu_decode_pkg::OP_HINT_OFFSET);
        i_fetch.issue(32'h4c43_000f, 32'h0, 8'h00, 4'hf, 2'b00);
        ck_cls(cpu_decode_pkg::OP_HINT_INDEXED);
        // unit 3 belongs to float and is gated by the unit 1 enable
        i_fetch.issue(32'h4c00_0000, 32'h0, 8'h00, 4'hd, 2'b00);
        check("unit3", 32'({unit, unu}), 32'h7);
        i_fetch.issue(32'h0420_0010, 32'h0, 8'h00, 4'hf, 2'b00);
        check("tgt_fn", 32'(tfn), 32'h1);
        // unassigned register-immediate function and unassigned function code
        i_fetch.issue(32'h0414_0000, 32'h0, 8'h00, 4'hf, 2'b00);
        check("register_immediate_group_rsv", 32'({tfn, rsv}), 32'h3);
        i_fetch.issue(32'h0000_0005, 32'h0, 8'h00, 4'hf, 2'b00);
        ck_cls(cpu_decode_pkg::OP_RESERVED);
    endtask : t_cop

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge i_clock);
        #1;
        i_rst_n = 1'b1;
        t_fields();
        t_nop();
        t_copy();
        t_cop();
        end_sim();
    end

    initial begin
        #8000;
        err_count++;
        end_sim();
    end
endmodule : cpu_instruction_decode_tb
`default_nettype wire
